// ### hw/slb_loader.sv
// slb_loader: boot-time serial command interpreter for the RAM loader operation.
// assumes: an external UART hands over received bytes with error flags and takes
// transmit bytes by valid/ready; memory reads return data one cycle after request.
//
// Overview of operation
// - first four bytes run at initial rate
// - echo matching byte; otherwise transmit nothing
// - errors sent as three identical bytes, then halt
// - fifth byte onward at modified rate
// - echo valid command as sixth byte
// - unknown command: command error thrice, halt
// - take count address high, low; no reply
// - take compare address high, low; no reply
// - erased top 32 bytes skip password
// - password mismatch halts silently until reset
// - read protection halts silently until reset
// - receive error in password phase halts silently
// - discard bytes until colon start mark
// - nothing echoed during record phase
// - parse record fields; store data at address
// - receive or format error halts silently
// - after clean end record send sum high, low
// - then jump to first data record address
// - auto rate on matching byte while waiting
// - valid rate byte echoed, then rate applies
// - read count N, compare N password bytes
`timescale 1ns/1ps
`default_nettype none

module slb_loader
   import slb_pkg::*;
#(
   // accepted rate-change codes for the operating frequency, five slots
   parameter logic [39:0] RATE_TABLE = {8'h28, 8'h28, 8'h28, 8'h28, 8'h28}
) (
   input  wire logic        CORE_CLK,
   input  wire logic        SYS_RST,
   input  wire logic        RX_VALID,
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        RX_ERR,
   input  wire logic        RX_OVR,
   input  wire logic        TX_READY,
   output logic             TX_VALID,
   output logic [7:0]       TX_DATA,
   output logic             AUTOBAUD,
   output logic [7:0]       RATE_CODE,
   output logic             RATE_SWITCH,
   input  wire logic        READ_PROTECT,
   output logic             MEM_RD_EN,
   output logic [15:0]      MEM_RD_ADDR,
   input  wire logic [7:0]  MEM_RD_DATA,
   output logic             RAM_WE,
   output logic [15:0]      RAM_ADDR,
   output logic [7:0]       RAM_WDATA,
   output logic             JUMP,
   output logic [15:0]      JUMP_ADDR,
   output logic             HALTED
);

   typedef struct packed {
      slb_state_e  st;
      slb_state_e  ret;         // state after a send or a memory read
      logic [1:0]  rep;         // repeats left of the byte being sent
      logic        tx_valid;
      logic [7:0]  tx_data;
      logic        autobaud;
      logic [7:0]  rate_code;
      logic        rate_switch;
      logic        rd_en;
      logic [15:0] rd_addr;
      logic [15:0] pcnt_addr;   // password count storage address
      logic [15:0] pcmp_addr;   // password comparison pointer
      logic [4:0]  blank_idx;
      logic [7:0]  pw_left;
      logic [7:0]  pw_byte;
      slb_field_e  fld;
      logic [7:0]  rec_type;
      logic [7:0]  rec_cnt;
      logic [15:0] rec_addr;
      logic [7:0]  rec_csum;
      logic [15:0] sum;
      logic        have_first;
      logic        ram_we;
      logic [15:0] ram_addr;
      logic [7:0]  ram_wdata;
      logic        jump;
      logic [15:0] jump_addr;
      logic        halted;
   } slb_regs_s;

   slb_regs_s r_q;
   slb_regs_s r_d;

   // start sending a byte, optionally repeated, then continue in ret
   function automatic slb_regs_s send(input slb_regs_s s, input logic [7:0] b,
                                      input slb_state_e ret, input logic [1:0] rep);
      slb_regs_s t;
      t          = s;
      t.tx_valid = 1'b1;
      t.tx_data  = b;
      t.ret      = ret;
      t.rep      = rep;
      t.st       = SLB_ST_SEND;
      return t;
   endfunction : send
   // start a memory read; data is taken in state ret
   function automatic slb_regs_s mem_read(input slb_regs_s s, input logic [15:0] a,
                                          input slb_state_e ret);
      slb_regs_s t;
      t         = s;
      t.rd_en   = 1'b1;
      t.rd_addr = a;
      t.ret     = ret;
      t.st      = SLB_ST_RD_WAIT;
      return t;
   endfunction : mem_read
   // rate byte acceptable for this operating frequency: any of the five slots
   function automatic logic rate_ok(input logic [7:0] b);
      return (RATE_TABLE[39:32] == b) || (RATE_TABLE[31:24] == b) || (RATE_TABLE[23:16] == b) ||
             (RATE_TABLE[15:8] == b) || (RATE_TABLE[7:0] == b);
   endfunction : rate_ok

   // receive error flags and the matching error code; overrun wins
   wire logic       rx_bad      = RX_ERR | RX_OVR;
   wire logic [7:0] rx_err_code = RX_OVR ? SLB_ERR_RXOVR : SLB_ERR_RXFRM;

   // next-state logic of the whole interpreter
   always_comb begin
      r_d        = r_q;
      r_d.ram_we = 1'b0;
      r_d.rd_en  = 1'b0;
      unique case (r_q.st)
         // wait for sync byte under automatic rate detection
         SLB_ST_MATCH: begin
            if (RX_VALID && !rx_bad && RX_DATA == SLB_MATCH_BYTE) begin
               r_d          = send(r_d, SLB_MATCH_BYTE, SLB_ST_RATE, 2'h0);
               r_d.autobaud = 1'b0;
            end
         end
         // hold the byte until taken; repeat error codes
         SLB_ST_SEND: begin
            if (TX_READY && r_q.rep != 2'h0) begin
               r_d.rep = r_q.rep - 2'h1;
            end else if (TX_READY) begin
               r_d.tx_valid = 1'b0;
               r_d.st       = r_q.ret;
            end
         end
         // rate-change byte, still at the initial rate
         SLB_ST_RATE: begin
            if (RX_VALID && rx_bad) begin
               r_d = send(r_d, rx_err_code, SLB_ST_HALT, SLB_ERR_REPEAT);
            end else if (RX_VALID && rate_ok(RX_DATA)) begin
               r_d.rate_code = RX_DATA;
               r_d = send(r_d, RX_DATA, SLB_ST_RATE_SET, 2'h0);
            end else if (RX_VALID) begin
               r_d = send(r_d, SLB_ERR_RATE, SLB_ST_HALT, SLB_ERR_REPEAT);
            end
         end
         // new rate takes effect only after its echo has gone out
         SLB_ST_RATE_SET: begin
            r_d.rate_switch = 1'b1;
            r_d.st          = SLB_ST_CMD;
         end
         // operation command
         SLB_ST_CMD: begin
            if (RX_VALID && rx_bad) begin
               r_d = send(r_d, rx_err_code, SLB_ST_HALT, SLB_ERR_REPEAT);
            end else if (RX_VALID && RX_DATA != SLB_CMD_RAMLOAD) begin
               r_d = send(r_d, SLB_ERR_CMD, SLB_ST_HALT, SLB_ERR_REPEAT);
            end else if (RX_VALID && READ_PROTECT) begin
               r_d.st = SLB_ST_HALT;
            end else if (RX_VALID) begin
               r_d = send(r_d, RX_DATA, SLB_ST_PCNT_HI, 2'h0);
            end
         end
         // password addresses, never acknowledged
         SLB_ST_PCNT_HI, SLB_ST_PCNT_LO, SLB_ST_PCMP_HI, SLB_ST_PCMP_LO: begin
            if (RX_VALID) begin
               if (rx_bad) begin
                  r_d.st = SLB_ST_HALT;
               end else begin
                  unique case (r_q.st)
                     SLB_ST_PCNT_HI: begin
                        r_d.pcnt_addr[15:8] = RX_DATA;
                        r_d.st              = SLB_ST_PCNT_LO;
                     end
                     SLB_ST_PCNT_LO: begin
                        r_d.pcnt_addr[7:0] = RX_DATA;
                        r_d.st             = SLB_ST_PCMP_HI;
                     end
                     SLB_ST_PCMP_HI: begin
                        r_d.pcmp_addr[15:8] = RX_DATA;
                        r_d.st              = SLB_ST_PCMP_LO;
                     end
                     default: begin
                        r_d.pcmp_addr[7:0] = RX_DATA;
                        r_d.blank_idx      = 5'h00;
                        r_d = mem_read(r_d, SLB_BLANK_BASE, SLB_ST_BLANK);
                     end
                  endcase
               end
            end
         end
         // one idle cycle while memory answers
         SLB_ST_RD_WAIT: begin
            r_d.st = r_q.ret;
         end
         // blank check over the top 32 bytes
         SLB_ST_BLANK: begin
            if (MEM_RD_DATA != SLB_ERASED) begin
               r_d = mem_read(r_d, r_q.pcnt_addr, SLB_ST_CNT);
            end else if (r_q.blank_idx == SLB_BLANK_LAST) begin
               r_d.st = SLB_ST_MARK;
            end else begin
               r_d.blank_idx = r_q.blank_idx + 5'h01;
               r_d = mem_read(r_d, SLB_BLANK_BASE + {11'h000, r_d.blank_idx}, SLB_ST_BLANK);
            end
         end
         // password length N from memory
         SLB_ST_CNT: begin
            r_d.pw_left = MEM_RD_DATA;
            r_d.st      = (MEM_RD_DATA == 8'h00) ? SLB_ST_MARK : SLB_ST_PW_RX;
         end
         // one password byte, then fetch its reference
         SLB_ST_PW_RX: begin
            if (RX_VALID && rx_bad) begin
               r_d.st = SLB_ST_HALT;
            end else if (RX_VALID) begin
               r_d.pw_byte = RX_DATA;
               r_d = mem_read(r_d, r_q.pcmp_addr, SLB_ST_PW_CHK);
            end
         end
         // compare; any mismatch halts without a word
         SLB_ST_PW_CHK: begin
            if (MEM_RD_DATA != r_q.pw_byte) begin
               r_d.st = SLB_ST_HALT;
            end else begin
               r_d.pcmp_addr = r_q.pcmp_addr + 16'h0001;
               r_d.pw_left   = r_q.pw_left - 8'h01;
               r_d.st        = (r_q.pw_left == 8'h01) ? SLB_ST_MARK : SLB_ST_PW_RX;
            end
         end
         // hunt for the start mark, dropping other clean bytes; a receive error halts
         SLB_ST_MARK: begin
            if (RX_VALID && rx_bad) begin
               r_d.st = SLB_ST_HALT;
            end else if (RX_VALID && RX_DATA == SLB_START_MARK) begin
               r_d.fld      = SLB_F_LEN;
               r_d.rec_csum = 8'h00;
               r_d.st       = SLB_ST_REC;
            end
         end
         // record fields in order; nothing is echoed here
         SLB_ST_REC: begin
            if (RX_VALID) begin
               r_d.rec_csum = r_q.rec_csum + RX_DATA;
               if (rx_bad) begin
                  r_d.st = SLB_ST_HALT;
               end else begin
                  unique case (r_q.fld)
                     SLB_F_LEN: begin
                        r_d.rec_cnt = RX_DATA;
                        r_d.fld     = SLB_F_AHI;
                     end
                     SLB_F_AHI: begin
                        r_d.rec_addr[15:8] = RX_DATA;
                        r_d.fld            = SLB_F_ALO;
                     end
                     SLB_F_ALO: begin
                        r_d.rec_addr[7:0] = RX_DATA;
                        r_d.fld           = SLB_F_TYPE;
                     end
                     SLB_F_TYPE: begin
                        r_d.rec_type = RX_DATA;
                        if (RX_DATA == SLB_REC_DATA) begin
                           r_d.fld = (r_q.rec_cnt == 8'h00) ? SLB_F_CSUM : SLB_F_DATA;
                           if (!r_q.have_first) begin
                              r_d.have_first = 1'b1;
                              r_d.jump_addr  = r_q.rec_addr;
                           end
                        end else if (RX_DATA == SLB_REC_END && r_q.rec_cnt == 8'h00) begin
                           r_d.fld = SLB_F_CSUM;
                        end else begin
                           r_d.st = SLB_ST_HALT;
                        end
                     end
                     SLB_F_DATA: begin
                        r_d.ram_we    = 1'b1;
                        r_d.ram_addr  = r_q.rec_addr;
                        r_d.ram_wdata = RX_DATA;
                        r_d.rec_addr  = r_q.rec_addr + 16'h0001;
                        r_d.sum       = r_q.sum + {8'h00, RX_DATA};
                        r_d.rec_cnt   = r_q.rec_cnt - 8'h01;
                        r_d.fld       = (r_q.rec_cnt == 8'h01) ? SLB_F_CSUM : SLB_F_DATA;
                     end
                     default: begin
                        if (r_d.rec_csum != 8'h00) begin
                           r_d.st = SLB_ST_HALT;
                        end else if (r_q.rec_type == SLB_REC_END) begin
                           r_d = send(r_d, r_q.sum[15:8], SLB_ST_SUM_LO, 2'h0);
                        end else begin
                           r_d.st = SLB_ST_MARK;
                        end
                     end
                  endcase
               end
            end
         end
         // low checksum byte follows the high one
         SLB_ST_SUM_LO: begin
            r_d = send(r_d, r_q.sum[7:0], SLB_ST_JUMP, 2'h0);
         end
         // hand execution to the loaded code
         SLB_ST_JUMP: begin
            r_d.jump = 1'b1;
         end
         // dead until reset
         SLB_ST_HALT: begin
            r_d.halted   = 1'b1;
            r_d.tx_valid = 1'b0;
         end
         default: begin
            r_d.st = SLB_ST_HALT;
         end
      endcase
   end

   // state register
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         r_q             <= '0;
         r_q.st          <= SLB_ST_MATCH;
         r_q.ret         <= SLB_ST_MATCH;
         r_q.fld         <= SLB_F_LEN;
         r_q.autobaud    <= 1'b1;
         r_q.rate_code   <= SLB_RATE_INIT;
         r_q.rd_addr     <= SLB_ADDR_RST;
         r_q.jump_addr   <= SLB_ADDR_RST;
         r_q.tx_data     <= SLB_BYTE_RST;
      end else begin
         r_q <= r_d;
      end
   end

   // outputs straight from the state register
   assign TX_VALID    = r_q.tx_valid;
   assign TX_DATA     = r_q.tx_data;
   assign AUTOBAUD    = r_q.autobaud;
   assign RATE_CODE   = r_q.rate_code;
   assign RATE_SWITCH = r_q.rate_switch;
   assign MEM_RD_EN   = r_q.rd_en;
   assign MEM_RD_ADDR = r_q.rd_addr;
   assign RAM_WE      = r_q.ram_we;
   assign RAM_ADDR    = r_q.ram_addr;
   assign RAM_WDATA   = r_q.ram_wdata;
   assign JUMP        = r_q.jump;
   assign JUMP_ADDR   = r_q.jump_addr;
   assign HALTED      = r_q.halted;

endmodule : slb_loader

`default_nettype wire

// ### hw/slb_pkg.sv
// slb_pkg: constants and types for the serial RAM loader boot interpreter.
// assumes: a byte-level UART outside the block delivers and takes whole bytes.
package slb_pkg;

   // protocol byte values
   localparam logic [7:0]  SLB_MATCH_BYTE  = 8'h5a;  // sync byte, echoed on success
   localparam logic [7:0]  SLB_CMD_RAMLOAD = 8'h60;  // RAM loader operation command
   localparam logic [7:0]  SLB_ERR_RXFRM   = 8'ha1;  // receive (framing) error code
   localparam logic [7:0]  SLB_ERR_RXOVR   = 8'ha3;  // receive overrun error code
   localparam logic [7:0]  SLB_ERR_RATE    = 8'h62;  // rate-change byte error code
   localparam logic [7:0]  SLB_ERR_CMD     = 8'h63;  // operation command error code
   localparam logic [7:0]  SLB_START_MARK  = 8'h3a;  // record start mark
   localparam logic [7:0]  SLB_RATE_INIT   = 8'h28;  // rate code of the initial rate
   localparam logic [7:0]  SLB_ERASED      = 8'hff;  // erased memory byte
   localparam logic [7:0]  SLB_REC_DATA    = 8'h00;  // data record type
   localparam logic [7:0]  SLB_REC_END     = 8'h01;  // end record type

   // blank check window at the top of memory
   localparam logic [15:0] SLB_BLANK_BASE  = 16'hffe0;
   localparam logic [4:0]  SLB_BLANK_LAST  = 5'h1f;   // 32 bytes, index 0..31

   // error code is sent once plus this many repeats
   localparam logic [1:0]  SLB_ERR_REPEAT  = 2'h2;

   // reset values of exposed state
   localparam logic [15:0] SLB_ADDR_RST    = 16'h0000;
   localparam logic [7:0]  SLB_BYTE_RST    = 8'h00;

   typedef enum logic [4:0] {
      SLB_ST_MATCH    = 5'h00,
      SLB_ST_SEND     = 5'h01,
      SLB_ST_RATE     = 5'h02,
      SLB_ST_RATE_SET = 5'h03,
      SLB_ST_CMD      = 5'h04,
      SLB_ST_PCNT_HI  = 5'h05,
      SLB_ST_PCNT_LO  = 5'h06,
      SLB_ST_PCMP_HI  = 5'h07,
      SLB_ST_PCMP_LO  = 5'h08,
      SLB_ST_RD_WAIT  = 5'h09,
      SLB_ST_BLANK    = 5'h0a,
      SLB_ST_CNT      = 5'h0b,
      SLB_ST_PW_RX    = 5'h0c,
      SLB_ST_PW_CHK   = 5'h0d,
      SLB_ST_MARK     = 5'h0e,
      SLB_ST_REC      = 5'h0f,
      SLB_ST_SUM_LO   = 5'h10,
      SLB_ST_JUMP     = 5'h11,
      SLB_ST_HALT     = 5'h12
   } slb_state_e;

   typedef enum logic [2:0] {
      SLB_F_LEN  = 3'h0,
      SLB_F_AHI  = 3'h1,
      SLB_F_ALO  = 3'h2,
      SLB_F_TYPE = 3'h3,
      SLB_F_DATA = 3'h4,
      SLB_F_CSUM = 3'h5
   } slb_field_e;

endpackage : slb_pkg

// ### testbench/slb_loader_sva.sv
// slb_loader_sva: port-level checks of the loader interpreter.
// assumes: bound onto slb_loader, one clock, reset active high.
`timescale 1ns/1ps
`default_nettype none
module slb_loader_sva
   import slb_pkg::*;
(
   input wire logic        CORE_CLK,
   input wire logic        SYS_RST,
   input wire logic        RX_VALID,
   input wire logic [7:0]  RX_DATA,
   input wire logic        RX_ERR,
   input wire logic        RX_OVR,
   input wire logic        TX_READY,
   input wire logic        TX_VALID,
   input wire logic [7:0]  TX_DATA,
   input wire logic        AUTOBAUD,
   input wire logic [7:0]  RATE_CODE,
   input wire logic        RATE_SWITCH,
   input wire logic        MEM_RD_EN,
   input wire logic        RAM_WE,
   input wire logic [7:0]  RAM_WDATA,
   input wire logic        JUMP,
   input wire logic [15:0] JUMP_ADDR,
   input wire logic        HALTED
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // transmit handshake
   wire tx_hs = TX_VALID && TX_READY;
   echo_match_a: assert property (AUTOBAUD && RX_VALID && RX_DATA == SLB_MATCH_BYTE && !RX_ERR && !RX_OVR
      |=> TX_VALID && TX_DATA == SLB_MATCH_BYTE && !AUTOBAUD) else $error("sync byte not echoed");
   tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
      else $error("tx byte dropped before taken");
   rate_apply_a: assert property ($rose(RATE_SWITCH) |-> $past(tx_hs) || $past(tx_hs, 2))
      else $error("rate switch without echo");
   rate_hold_a: assert property (RATE_SWITCH |=> RATE_SWITCH && $stable(RATE_CODE))
      else $error("modified rate not kept");
   halt_quiet_a: assert property (HALTED |=> HALTED && !TX_VALID)
      else $error("halted device transmits");
   halt_drain_a: assert property ($rose(HALTED) |-> $past(!TX_VALID))
      else $error("halt before error bytes drained");
   rec_quiet_a: assert property (RAM_WE |-> !TX_VALID && !HALTED)
      else $error("transmit during record phase");
   ram_data_a: assert property (RAM_WE |-> $past(RX_VALID) && RAM_WDATA == $past(RX_DATA))
      else $error("ram data differs from received byte");
   ram_pulse_a: assert property (RAM_WE |=> !RAM_WE)
      else $error("ram write longer than one cycle");
   jump_hold_a: assert property (JUMP |=> JUMP && $stable(JUMP_ADDR) && !TX_VALID)
      else $error("jump not held");
   jump_after_a: assert property ($rose(JUMP) |-> $past(tx_hs) || $past(tx_hs, 2) || $past(tx_hs, 3))
      else $error("jump without sum sent");
   read_pulse_a: assert property (MEM_RD_EN |=> !MEM_RD_EN)
      else $error("memory reads back to back");
endmodule : slb_loader_sva
bind slb_loader slb_loader_sva u_sva (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .RX_VALID(RX_VALID),
   .RX_DATA(RX_DATA), .RX_ERR(RX_ERR), .RX_OVR(RX_OVR), .TX_READY(TX_READY), .TX_VALID(TX_VALID),
   .TX_DATA(TX_DATA), .AUTOBAUD(AUTOBAUD), .RATE_CODE(RATE_CODE), .RATE_SWITCH(RATE_SWITCH),
   .MEM_RD_EN(MEM_RD_EN), .RAM_WE(RAM_WE), .RAM_WDATA(RAM_WDATA), .JUMP(JUMP),
   .JUMP_ADDR(JUMP_ADDR), .HALTED(HALTED));
`default_nettype wire

// ### testbench/slb_host_model.sv
// slb_host_model: programming controller side and boot memory.
// assumes: uart byte level; memory answers one cycle after request.
`timescale 1ns/1ps
`default_nettype none
module slb_host_model (
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data,
   output logic             tx_ready,
   input  wire logic        rd_en,
   input  wire logic [15:0] rd_addr,
   output logic [7:0]       rd_data
);
   logic [7:0] mem [0:65535];
   logic [7:0] got_q [$];
   logic [1:0] div;
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      div = 2'h0;
      tx_ready = 1'b0;
      rd_data = 8'h00;
   end
   // collect every byte the device sends on a handshake, sum bytes included
   always @(posedge clk) begin
      if (tx_valid && tx_ready) got_q.push_back(tx_data);
      div <= div + 2'h1;
   end
   // stalls when slow: ready one cycle in four
   always @(negedge clk) tx_ready <= !slow || (div == 2'h0);
   // read data valid the cycle after request, junk otherwise
   always @(posedge clk) rd_data <= rd_en ? mem[rd_addr] : ~rd_data;
endmodule : slb_host_model
`default_nettype wire

// ### testbench/slb_loader_tb.sv
// slb_loader_tb: scenarios for the loader interpreter.
// assumes: slb_host_model answers tx and memory.
`timescale 1ns/1ps
`default_nettype none
module slb_loader_tb;
   import slb_pkg::*;
   logic core_clk, sys_rst, rx_valid, rx_err, rx_ovr, read_protect, slow, tx_ready, tx_valid;
   logic autobaud, rate_switch, mem_rd_en, ram_we, jump, halted;
   logic [7:0] rx_data, tx_data, rate_code, mem_rd_data, ram_wdata;
   logic [15:0] mem_rd_addr, ram_addr, jump_addr;
   logic [7:0] exp_q [$];
   logic [23:0] ram_q [$];
   int errors = 0;
   int check_count = 0;
   slb_loader dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .RX_VALID(rx_valid), .RX_DATA(rx_data),
      .RX_ERR(rx_err), .RX_OVR(rx_ovr), .TX_READY(tx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
      .AUTOBAUD(autobaud), .RATE_CODE(rate_code), .RATE_SWITCH(rate_switch),
      .READ_PROTECT(read_protect), .MEM_RD_EN(mem_rd_en), .MEM_RD_ADDR(mem_rd_addr),
      .MEM_RD_DATA(mem_rd_data), .RAM_WE(ram_we), .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata),
      .JUMP(jump), .JUMP_ADDR(jump_addr), .HALTED(halted));
   slb_host_model host (.clk(core_clk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .rd_en(mem_rd_en), .rd_addr(mem_rd_addr), .rd_data(mem_rd_data));
   // log ram writes
   always @(posedge core_clk) if (ram_we === 1'b1) ram_q.push_back({ram_addr, ram_wdata});
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic final_report();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc
   task automatic reset_dut();
      sys_rst = 1'b1;
      cyc(8);
      host.got_q.delete();
      exp_q.delete();
      ram_q.delete();
      sys_rst = 1'b0;
   endtask : reset_dut
   // one byte from the controller; the line then shows junk
   task automatic send(input logic [7:0] b, input logic [1:0] f = 2'h0);
      @(negedge core_clk);
      rx_valid = 1'b1;
      rx_data = b;
      {rx_err, rx_ovr} = f;
      @(negedge core_clk);
      rx_valid = 1'b0;
      {rx_err, rx_ovr} = 2'h0;
      rx_data = ~b;
      cyc(12);
   endtask : send
   // compare device output with exp_q
   task automatic chk_tx();
      chk(host.got_q.size(), exp_q.size());
      foreach (exp_q[i]) if (i < host.got_q.size()) chk(host.got_q[i], exp_q[i]);
   endtask : chk_tx
   task automatic preamble(input logic [7:0] rate, cmd, input logic [1:0] rf, cf);
      reset_dut();
      send(8'h13);
      send(SLB_MATCH_BYTE);
      send(rate, rf);
      send(cmd, cf);
   endtask : preamble
   task automatic addrs(input logic [15:0] c, p);
      send(c[15:8]);
      send(c[7:0]);
      send(p[15:8]);
      send(p[7:0]);
      cyc(100);
   endtask : addrs
   task automatic sc_bad_rate();
      preamble(8'h55, SLB_CMD_RAMLOAD, 2'h0, 2'h0);
      send(SLB_MATCH_BYTE);
      exp_q = '{8'h5a, 8'h62, 8'h62, 8'h62};
      chk_tx();
      chk(halted, 1'b1);
   endtask : sc_bad_rate
   task automatic sc_bad_cmd();
      preamble(SLB_RATE_INIT, 8'h61, 2'h0, 2'h0);
      exp_q = '{8'h5a, 8'h28, 8'h63, 8'h63, 8'h63};
      chk_tx();
      chk(halted, 1'b1);
   endtask : sc_bad_cmd
   task automatic sc_rx_faults();
      preamble(SLB_RATE_INIT, SLB_CMD_RAMLOAD, 2'h2, 2'h0);
      exp_q = '{8'h5a, 8'ha1, 8'ha1, 8'ha1};
      chk_tx();
      preamble(SLB_RATE_INIT, SLB_CMD_RAMLOAD, 2'h0, 2'h1);
      exp_q = '{8'h5a, 8'h28, 8'ha3, 8'ha3, 8'ha3};
      chk_tx();
      preamble(SLB_RATE_INIT, SLB_CMD_RAMLOAD, 2'h0, 2'h0);
      send(8'h01, 2'h1);
      exp_q = '{8'h5a, 8'h28, 8'h60};
      chk_tx();
      chk(halted, 1'b1);
   endtask : sc_rx_faults
   task automatic sc_protect();
      read_protect = 1'b1;
      preamble(SLB_RATE_INIT, SLB_CMD_RAMLOAD, 2'h0, 2'h0);
      read_protect = 1'b0;
      exp_q = '{8'h5a, 8'h28};
      chk_tx();
      chk(halted, 1'b1);
   endtask : sc_protect
   task automatic sc_pw_fail();
      host.mem[16'hffe0] = 8'h00;
      host.mem[16'h0100] = 8'h02;
      host.mem[16'h0200] = 8'hab;
      host.mem[16'h0201] = 8'hcd;
      preamble(SLB_RATE_INIT, SLB_CMD_RAMLOAD, 2'h0, 2'h0);
      addrs(16'h0100, 16'h0200);
      send(8'hab);
      send(8'hcd);
      chk(halted, 1'b0);
      preamble(SLB_RATE_INIT, SLB_CMD_RAMLOAD, 2'h0, 2'h0);
      addrs(16'h0100, 16'h0200);
      send(8'hab);
      send(8'h00);
      host.mem[16'hffe0] = 8'hff;
      exp_q = '{8'h5a, 8'h28, 8'h60};
      chk_tx();
      chk(halted, 1'b1);
   endtask : sc_pw_fail
   task automatic sc_bad_rec();
      preamble(SLB_RATE_INIT, SLB_CMD_RAMLOAD, 2'h0, 2'h0);
      addrs(16'h0100, 16'h0200);
      exp_q = '{8'h3a, 8'h01, 8'h00, 8'h10, 8'h00, 8'h55, 8'h00};
      foreach (exp_q[i]) send(exp_q[i]);
      exp_q = '{8'h5a, 8'h28, 8'h60};
      chk_tx();
      chk(halted, 1'b1);
   endtask : sc_bad_rec
   task automatic sc_blank_load();
      slow = 1'b1;
      preamble(SLB_RATE_INIT, SLB_CMD_RAMLOAD, 2'h0, 2'h0);
      chk({rate_switch, rate_code}, 9'h128);
      addrs(16'h0100, 16'h0200);
      exp_q = '{8'h00, 8'h3a, 8'h02, 8'h12, 8'h34, 8'h00, 8'h11, 8'h22, 8'h85,
                8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff};
      foreach (exp_q[i]) send(exp_q[i]);
      for (int i = 0; i < 60 && jump !== 1'b1; i++) cyc(1);
      chk(jump, 1'b1);
      if (jump !== 1'b1) return;
      slow = 1'b0;
      exp_q = '{8'h5a, 8'h28, 8'h60, 8'h00, 8'h33};
      chk_tx();
      chk(jump_addr, 16'h1234);
      chk(ram_q.size(), 2);
      chk(ram_q[0], 24'h123411);
      chk(ram_q[1], 24'h123522);
   endtask : sc_blank_load
   initial begin
      {sys_rst, rx_valid, rx_err, rx_ovr, read_protect, slow} = 6'h20;
      rx_data = 8'h00;
      sc_bad_rate();
      sc_bad_cmd();
      sc_rx_faults();
      sc_protect();
      sc_pw_fail();
      sc_bad_rec();
      sc_blank_load();
      final_report();
   end
endmodule : slb_loader_tb
`default_nettype wire
